// ===== shared/sat_pkg.sv
// constants, types and helpers shared by the segment address translator
package sat_pkg;
   localparam int PA_W = 32;
   localparam int RA_W = 24;
   localparam int ENT_W = 32;
   localparam int OFF_W = 16;
   // segment table entry field positions
   localparam int REF_BIT = 0;
   localparam int PRES_BIT = 1;
   localparam int DIRTY_BIT = 2;
   localparam int RD_EN_BIT = 3;
   localparam int WR_EN_BIT = 4;
   localparam int EX_EN_BIT = 5;
   localparam int LVL_LO = 6;
   localparam int LVL_HI = 7;
   localparam int SHR_BIT = 8;
   localparam int LIM_LO = 10;
   localparam int LIM_HI = 14;
   localparam int REL_LO = 15;
   localparam int REL_HI = 31;
   // descriptor field positions
   localparam int DSC_SIZE_LO = 2;
   localparam int DSC_SIZE_HI = 14;
   localparam int DSC_BASE_LO = 15;
   localparam int DSC_BASE_HI = 31;
   // program address fields
   localparam int SEG_LO = 8;
   localparam int SEG_HI = 15;
   localparam int VLIM_LO = 8;
   localparam int VLIM_HI = 12;
   // protection cause codes
   localparam logic [1:0] CAUSE_EXEC = 2'h0;
   localparam logic [1:0] CAUSE_WRITE = 2'h1;
   localparam logic [1:0] CAUSE_READ = 2'h2;
   localparam logic [1:0] CAUSE_LEVEL = 2'h3;
   // values after reset
   localparam logic [RA_W-1:0] RA_RST = 24'h000000;
   localparam logic [ENT_W-1:0] ENT_RST = 32'h00000000;
   localparam logic [PA_W-1:0] DSC_RST = 32'h00000000;

   typedef enum logic [1:0] {ACC_READ, ACC_WRITE, ACC_EXEC} sat_acc_t;

   typedef enum logic [2:0] {
      FLT_NONE, FLT_PROT, FLT_ABSENT, FLT_LIMIT, FLT_SEG_CNT, FLT_SHR_SIZE, FLT_SHR_OFF
   } sat_flt_t;

   typedef struct packed {
      logic [PA_W-1:0] prog_addr;
      sat_acc_t acc;
      logic dma;
   } sat_req_t;

   typedef struct packed {
      sat_flt_t kind;
      logic [1:0] cause;
   } sat_fault_t;

   // base field is in 128-byte units, offset in bytes
   function automatic logic [RA_W-1:0] sat_tbl_addr(input logic [16:0] base, input logic [RA_W-1:0] off);
      return {base, 7'h00} + off;
   endfunction
endpackage

// ===== hdl/sat_addr_calc.sv
// table entry addresses, walk faults and relocated address
`timescale 1ns/1ns
module sat_addr_calc (
   input wire logic [sat_pkg::PA_W-1:0] prog_addr_i,
   input wire logic [sat_pkg::PA_W-1:0] proc_desc_i,
   input wire logic [sat_pkg::PA_W-1:0] shr_desc_i,
   input wire logic [sat_pkg::ENT_W-1:0] proc_entry_i,
   input wire logic [sat_pkg::ENT_W-1:0] final_entry_i,
   output logic [sat_pkg::RA_W-1:0] proc_ent_addr_o,
   output logic [sat_pkg::RA_W-1:0] shr_ent_addr_o,
   output logic seg_over_o,
   output logic shr_size_flt_o,
   output logic shr_off_flt_o,
   output logic [sat_pkg::RA_W-1:0] real_addr_o
);
   logic [7:0] seg_idx;
   logic [12:0] seg_cnt, shr_size;
   logic [4:0] proc_size;
   logic [16:0] shr_off;

   assign seg_idx = prog_addr_i[sat_pkg::SEG_HI:sat_pkg::SEG_LO]; // RULE3
   assign seg_cnt = proc_desc_i[sat_pkg::DSC_SIZE_HI:sat_pkg::DSC_SIZE_LO];
   assign seg_over_o = {5'h00, seg_idx} > seg_cnt; // RULE4
   assign proc_ent_addr_o = sat_pkg::sat_tbl_addr(proc_desc_i[sat_pkg::DSC_BASE_HI:sat_pkg::DSC_BASE_LO],
      {13'h0000, seg_idx, 3'h0}); // RULE2 RULE3
   assign shr_size = shr_desc_i[sat_pkg::DSC_SIZE_HI:sat_pkg::DSC_SIZE_LO];
   assign proc_size = proc_entry_i[sat_pkg::LIM_HI:sat_pkg::LIM_LO];
   assign shr_size_flt_o = shr_size < {8'h00, proc_size}; // RULE6
   assign shr_off = proc_entry_i[sat_pkg::REL_HI:sat_pkg::REL_LO];
   assign shr_off_flt_o = shr_off > {1'b0, shr_size, 3'h0}; // RULE18
   assign shr_ent_addr_o = sat_pkg::sat_tbl_addr(shr_desc_i[sat_pkg::DSC_BASE_HI:sat_pkg::DSC_BASE_LO],
      {7'h00, shr_off}); // RULE5 RULE7 RULE15
   // relocation field is real address / 128, plus low offset
   assign real_addr_o = {final_entry_i[sat_pkg::REL_HI:sat_pkg::REL_LO], 7'h00}
      + {8'h00, prog_addr_i[sat_pkg::OFF_W-1:0]}; // RULE1 RULE17
endmodule

// ===== hdl/sat_entry_check.sv
// protection checks and flag update on the final segment entry
`timescale 1ns/1ns
module sat_entry_check (
   input wire logic [sat_pkg::ENT_W-1:0] entry_i,
   input wire logic [2:0] modes_i,
   input wire sat_pkg::sat_acc_t acc_i,
   input wire logic [1:0] level_i,
   input wire logic [4:0] virt_lim_i,
   output sat_pkg::sat_fault_t fault_o,
   output logic [sat_pkg::ENT_W-1:0] entry_o
);
   logic present, level_ok, mode_ok, lim_ok;
   logic [1:0] mode_cause;
   logic do_dirty;

   assign present = entry_i[sat_pkg::PRES_BIT];
   assign level_ok = level_i >= entry_i[sat_pkg::LVL_HI:sat_pkg::LVL_LO]; // RULE12
   assign mode_ok = modes_i[acc_i]; // RULE11
   assign mode_cause = (acc_i == sat_pkg::ACC_READ) ? sat_pkg::CAUSE_READ :
      (acc_i == sat_pkg::ACC_WRITE) ? sat_pkg::CAUSE_WRITE : sat_pkg::CAUSE_EXEC; // RULE21
   assign lim_ok = entry_i[sat_pkg::LIM_HI:sat_pkg::LIM_LO] >= virt_lim_i; // RULE16

   // absence hides all other fields; level is judged before mode
   always_comb begin
      fault_o.kind = sat_pkg::FLT_NONE;
      fault_o.cause = 2'h0;
      if (!present) begin
         fault_o.kind = sat_pkg::FLT_ABSENT; // RULE9
      end else if (!level_ok) begin
         fault_o.kind = sat_pkg::FLT_PROT; // RULE13
         fault_o.cause = sat_pkg::CAUSE_LEVEL; // RULE21
      end else if (!mode_ok) begin
         fault_o.kind = sat_pkg::FLT_PROT;
         fault_o.cause = mode_cause;
      end else if (!lim_ok) begin
         fault_o.kind = sat_pkg::FLT_LIMIT;
      end
   end

   assign do_dirty = present && (acc_i == sat_pkg::ACC_WRITE) && (fault_o.kind == sat_pkg::FLT_NONE);

   always_comb begin
      entry_o = entry_i;
      entry_o[sat_pkg::REF_BIT] = 1'b1; // RULE8 RULE9
      entry_o[sat_pkg::DIRTY_BIT] = entry_i[sat_pkg::DIRTY_BIT] | do_dirty; // RULE10
   end
endmodule

// ===== hdl/sat_translator.sv
// segment table walk, protection and address translation engine
// Behaviour
// RULE1: translation off passes address; on adds bias
// RULE2: process table of double-word entries, 32 bits used
// RULE3: descriptor base, address bits 15:8 index table
// RULE4: segment index above descriptor count faults
// RULE5: shared entries fetched from shared table
// RULE6: shared descriptor size below entry size faults
// RULE7: shared descriptor base plus process entry offset
// RULE8: reference flag set on access, not DMA
// RULE9: absent entry: only reference set, then fault
// RULE10: dirty set on program write of present segment
// RULE11: read, write, execute enable bits else fault
// RULE12: status level must reach entry access level
// RULE13: level check wins over mode check
// RULE14: software keeps shared bit zero in shared table
// RULE15: shared: AND modes, rest from shared entry
// RULE16: limit field below address bits 12:8 faults
// RULE17: private relocation field is address over 128
// RULE18: shared offset beyond table bytes faults
// RULE19: software clears trailing relocation bits
// RULE20: software zeroes reserved entry fields
// RULE21: cause codes execute, write, read, level
// RULE22: one fault strobe, memory access suppressed
`timescale 1ns/1ns
module sat_translator (
   input wire logic core_clk_i,
   input wire logic rst_i,
   // processor side
   input wire logic xlat_enable_i,
   input wire logic [sat_pkg::PA_W-1:0] proc_desc_i,
   input wire logic [sat_pkg::PA_W-1:0] shr_desc_i,
   input wire logic [1:0] pstat_level_i,
   input wire logic req_valid_i,
   input wire sat_pkg::sat_req_t req_i,
   output logic busy_o,
   output logic done_o,
   output logic fault_o,
   output sat_pkg::sat_fault_t fault_info_o,
   // translated memory access
   output logic mem_req_o,
   output logic [sat_pkg::RA_W-1:0] mem_addr_o,
   output sat_pkg::sat_acc_t mem_acc_o,
   // segment table access
   output logic tbl_rd_o,
   output logic tbl_wr_o,
   output logic [sat_pkg::RA_W-1:0] tbl_addr_o,
   output logic [sat_pkg::ENT_W-1:0] tbl_wdata_o,
   input wire logic [sat_pkg::ENT_W-1:0] tbl_rdata_i,
   input wire logic tbl_ack_i
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_PROC_RD, ST_SPLIT, ST_SHR_RD, ST_CHECK, ST_WB
   } sat_state_t;

   sat_state_t state_q;
   sat_state_t state_d;
   sat_pkg::sat_req_t req_q;
   sat_pkg::sat_req_t req_d;
   logic enable_q;
   logic enable_d;
   logic [1:0] level_q;
   logic [1:0] level_d;
   logic [sat_pkg::PA_W-1:0] pdesc_q;
   logic [sat_pkg::PA_W-1:0] pdesc_d;
   logic [sat_pkg::PA_W-1:0] sdesc_q;
   logic [sat_pkg::PA_W-1:0] sdesc_d;
   logic [sat_pkg::ENT_W-1:0] proc_ent_q;
   logic [sat_pkg::ENT_W-1:0] proc_ent_d;
   logic [sat_pkg::ENT_W-1:0] shr_ent_q;
   logic [sat_pkg::ENT_W-1:0] shr_ent_d;
   logic shared_q;
   logic shared_d;
   sat_pkg::sat_fault_t flt_q;
   sat_pkg::sat_fault_t flt_d;
   logic [sat_pkg::RA_W-1:0] real_q;
   logic [sat_pkg::RA_W-1:0] real_d;
   logic [sat_pkg::RA_W-1:0] tbl_addr_q;
   logic [sat_pkg::RA_W-1:0] tbl_addr_d;
   logic [sat_pkg::ENT_W-1:0] tbl_wdata_q;
   logic [sat_pkg::ENT_W-1:0] tbl_wdata_d;
   logic done_q;
   logic done_d;
   logic fault_q;
   logic fault_d;
   sat_pkg::sat_fault_t info_q;
   sat_pkg::sat_fault_t info_d;
   logic mem_req_q;
   logic mem_req_d;
   logic [sat_pkg::RA_W-1:0] mem_addr_q;
   logic [sat_pkg::RA_W-1:0] mem_addr_d;
   sat_pkg::sat_acc_t mem_acc_q;
   sat_pkg::sat_acc_t mem_acc_d;

   // walk decode
   logic [sat_pkg::ENT_W-1:0] final_entry;
   logic [2:0] modes;
   logic [sat_pkg::RA_W-1:0] proc_ent_addr;
   logic [sat_pkg::RA_W-1:0] shr_ent_addr;
   logic seg_over;
   logic shr_size_flt;
   logic shr_off_flt;
   logic [sat_pkg::RA_W-1:0] xlat_addr;
   sat_pkg::sat_fault_t chk_fault;
   logic [sat_pkg::ENT_W-1:0] chk_entry;
   logic proc_present;
   logic proc_shared;
   logic needs_wb;
   logic [4:0] virt_lim;

   // shared: modes ANDed, the rest from the shared entry
   assign final_entry = shared_q ? shr_ent_q : proc_ent_q; // RULE15
   assign modes = shared_q ?
      (proc_ent_q[sat_pkg::EX_EN_BIT:sat_pkg::RD_EN_BIT] & shr_ent_q[sat_pkg::EX_EN_BIT:sat_pkg::RD_EN_BIT]) :
      proc_ent_q[sat_pkg::EX_EN_BIT:sat_pkg::RD_EN_BIT]; // RULE15
   assign proc_present = proc_ent_q[sat_pkg::PRES_BIT];
   // shared bit only counts on a present entry
   assign proc_shared = proc_present && proc_ent_q[sat_pkg::SHR_BIT]; // RULE9 RULE14
   assign virt_lim = req_q.prog_addr[sat_pkg::VLIM_HI:sat_pkg::VLIM_LO];
   // dma leaves the entry as it was
   assign needs_wb = !req_q.dma && (chk_entry != final_entry); // RULE8 RULE10

   sat_addr_calc u_addr (
      .prog_addr_i(req_q.prog_addr),
      .proc_desc_i(pdesc_q),
      .shr_desc_i(sdesc_q),
      .proc_entry_i(proc_ent_q),
      .final_entry_i(final_entry),
      .proc_ent_addr_o(proc_ent_addr),
      .shr_ent_addr_o(shr_ent_addr),
      .seg_over_o(seg_over),
      .shr_size_flt_o(shr_size_flt),
      .shr_off_flt_o(shr_off_flt),
      .real_addr_o(xlat_addr)
   );

   sat_entry_check u_check (
      .entry_i(final_entry),
      .modes_i(modes),
      .acc_i(req_q.acc),
      .level_i(level_q),
      .virt_lim_i(virt_lim),
      .fault_o(chk_fault),
      .entry_o(chk_entry)
   );

   always_comb begin
      state_d = state_q;
      req_d = req_q;
      enable_d = enable_q;
      level_d = level_q;
      pdesc_d = pdesc_q;
      sdesc_d = sdesc_q;
      proc_ent_d = proc_ent_q;
      shr_ent_d = shr_ent_q;
      shared_d = shared_q;
      flt_d = flt_q;
      real_d = real_q;
      tbl_addr_d = tbl_addr_q;
      tbl_wdata_d = tbl_wdata_q;
      done_d = 1'b0;
      fault_d = 1'b0;
      info_d = info_q;
      mem_req_d = 1'b0;
      mem_addr_d = mem_addr_q;
      mem_acc_d = mem_acc_q;
      case (state_q)
         ST_IDLE: begin
            if (req_valid_i) begin
               // context frozen for the whole walk
               req_d = req_i;
               enable_d = xlat_enable_i;
               level_d = pstat_level_i;
               pdesc_d = proc_desc_i;
               sdesc_d = shr_desc_i;
               shared_d = 1'b0;
               flt_d = '0;
               state_d = ST_START;
            end
         end
         ST_START: begin
            if (!enable_q) begin
               real_d = req_q.prog_addr[sat_pkg::RA_W-1:0]; // RULE1
               state_d = ST_IDLE;
               done_d = 1'b1;
               mem_req_d = 1'b1;
               mem_addr_d = req_q.prog_addr[sat_pkg::RA_W-1:0]; // RULE1
               mem_acc_d = req_q.acc;
               info_d = '0;
            end else if (seg_over) begin
               state_d = ST_IDLE;
               done_d = 1'b1;
               fault_d = 1'b1; // RULE4 RULE22
               info_d = '{sat_pkg::FLT_SEG_CNT, 2'h0};
            end else begin
               tbl_addr_d = proc_ent_addr; // RULE3
               state_d = ST_PROC_RD;
            end
         end
         ST_PROC_RD: begin
            if (tbl_ack_i) begin
               proc_ent_d = tbl_rdata_i; // RULE2
               state_d = ST_SPLIT;
            end
         end
         ST_SPLIT: begin
            if (!proc_shared) begin
               state_d = ST_CHECK;
            end else if (shr_size_flt) begin
               // shared table never touched on a size mismatch
               state_d = ST_IDLE;
               done_d = 1'b1;
               fault_d = 1'b1; // RULE6 RULE22
               info_d = '{sat_pkg::FLT_SHR_SIZE, 2'h0};
            end else if (shr_off_flt) begin
               state_d = ST_IDLE;
               done_d = 1'b1;
               fault_d = 1'b1; // RULE18 RULE22
               info_d = '{sat_pkg::FLT_SHR_OFF, 2'h0};
            end else begin
               tbl_addr_d = shr_ent_addr; // RULE5 RULE7
               shared_d = 1'b1;
               state_d = ST_SHR_RD;
            end
         end
         ST_SHR_RD: begin
            if (tbl_ack_i) begin
               shr_ent_d = tbl_rdata_i; // RULE5
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            flt_d = chk_fault;
            real_d = xlat_addr; // RULE1 RULE7 RULE17
            tbl_wdata_d = chk_entry;
            tbl_addr_d = shared_q ? shr_ent_addr : proc_ent_addr;
            if (needs_wb) begin
               state_d = ST_WB; // RULE8
            end else begin
               state_d = ST_IDLE;
               done_d = 1'b1;
               fault_d = chk_fault.kind != sat_pkg::FLT_NONE; // RULE22
               info_d = chk_fault;
               mem_req_d = chk_fault.kind == sat_pkg::FLT_NONE; // RULE22
               mem_addr_d = xlat_addr;
               mem_acc_d = req_q.acc;
            end
         end
         ST_WB: begin
            // flags written back before the result is reported
            if (tbl_ack_i) begin
               state_d = ST_IDLE;
               done_d = 1'b1;
               fault_d = flt_q.kind != sat_pkg::FLT_NONE; // RULE22
               info_d = flt_q;
               mem_req_d = flt_q.kind == sat_pkg::FLT_NONE; // RULE22
               mem_addr_d = real_q;
               mem_acc_d = req_q.acc;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
         done_q <= 1'b0;
         fault_q <= 1'b0;
         mem_req_q <= 1'b0;
      end else begin
         state_q <= state_d;
         done_q <= done_d;
         fault_q <= fault_d;
         mem_req_q <= mem_req_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         req_q <= '0;
         enable_q <= 1'b0;
         level_q <= 2'h0;
         pdesc_q <= sat_pkg::DSC_RST;
         sdesc_q <= sat_pkg::DSC_RST;
      end else begin
         req_q <= req_d;
         enable_q <= enable_d;
         level_q <= level_d;
         pdesc_q <= pdesc_d;
         sdesc_q <= sdesc_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         proc_ent_q <= sat_pkg::ENT_RST;
         shr_ent_q <= sat_pkg::ENT_RST;
         shared_q <= 1'b0;
         flt_q <= '0;
         real_q <= sat_pkg::RA_RST;
      end else begin
         proc_ent_q <= proc_ent_d;
         shr_ent_q <= shr_ent_d;
         shared_q <= shared_d;
         flt_q <= flt_d;
         real_q <= real_d;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         tbl_addr_q <= sat_pkg::RA_RST;
         tbl_wdata_q <= sat_pkg::ENT_RST;
         info_q <= '0;
         mem_addr_q <= sat_pkg::RA_RST;
         mem_acc_q <= sat_pkg::ACC_READ;
      end else begin
         tbl_addr_q <= tbl_addr_d;
         tbl_wdata_q <= tbl_wdata_d;
         info_q <= info_d;
         mem_addr_q <= mem_addr_d;
         mem_acc_q <= mem_acc_d;
      end
   end

   assign busy_o = state_q != ST_IDLE;
   assign done_o = done_q;
   assign fault_o = fault_q; // RULE22
   assign fault_info_o = info_q; // RULE21
   assign mem_req_o = mem_req_q;
   assign mem_addr_o = mem_addr_q;
   assign mem_acc_o = mem_acc_q;
   assign tbl_rd_o = (state_q == ST_PROC_RD) || (state_q == ST_SHR_RD);
   assign tbl_wr_o = state_q == ST_WB;
   assign tbl_addr_o = tbl_addr_q;
   assign tbl_wdata_o = tbl_wdata_q;
endmodule

// ===== tb/sat_translator_properties.sv
// port-level assertions for the segment address translator
`timescale 1ns/1ns
module sat_translator_properties (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic xlat_enable_i,
   input wire logic [31:0] proc_desc_i,
   input wire logic req_valid_i,
   input wire sat_pkg::sat_req_t req_i,
   input wire logic busy_o,
   input wire logic done_o,
   input wire logic fault_o,
   input wire sat_pkg::sat_fault_t fault_info_o,
   input wire logic mem_req_o,
   input wire logic [23:0] mem_addr_o,
   input wire logic tbl_rd_o,
   input wire logic tbl_wr_o,
   input wire logic [23:0] tbl_addr_o,
   input wire logic [31:0] tbl_wdata_o,
   input wire logic [31:0] tbl_rdata_i,
   input wire logic tbl_ack_i
);
   logic take, en_q, dma_q;
   sat_pkg::sat_acc_t acc_q;
   logic [31:0] pa_q, pd_q, rd_q;
   logic [23:0] rda_q;
   logic [1:0] cause_x;
   assign take = req_valid_i && !busy_o;
   assign cause_x = sat_pkg::CAUSE_READ - 2'(acc_q);
   // request and last entry read
   always_ff @(posedge core_clk_i) begin
      if (take) begin
         en_q <= xlat_enable_i;
         dma_q <= req_i.dma;
         acc_q <= req_i.acc;
         pa_q <= req_i.prog_addr;
         pd_q <= proc_desc_i;
      end
      if (tbl_rd_o && tbl_ack_i) begin
         rd_q <= tbl_rdata_i;
         rda_q <= tbl_addr_o;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   property p_off_lat;
      take && !xlat_enable_i |=> ##1 (done_o && mem_req_o);
   endproperty
   a_off_lat: assert property (p_off_lat) else $error("pass-through late");
   property p_real_addr;
      mem_req_o |-> mem_addr_o == (en_q ? {rd_q[31:15], 7'h00} + {8'h00, pa_q[15:0]} : pa_q[23:0]);
   endproperty
   a_real_addr: assert property (p_real_addr) else $error("bad real address");
   property p_seg_cnt;
      take && xlat_enable_i && req_i.prog_addr[15:8] > proc_desc_i[14:2]
         |=> ##1 (done_o && fault_o && fault_info_o.kind == sat_pkg::FLT_SEG_CNT);
   endproperty
   a_seg_cnt: assert property (p_seg_cnt) else $error("no count fault");
   property p_first_read;
      take && xlat_enable_i && req_i.prog_addr[15:8] <= proc_desc_i[14:2]
         |=> ##1 tbl_addr_o == {pd_q[31:15], 7'h00} + {13'h0000, pa_q[15:8], 3'h0};
   endproperty
   a_first_read: assert property (p_first_read) else $error("bad entry address");
   property p_strobe;
      (fault_o || mem_req_o) |-> done_o && (fault_o ^ mem_req_o);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe clash");
   property p_cause;
      done_o && fault_o && fault_info_o.kind == sat_pkg::FLT_PROT && fault_info_o.cause != sat_pkg::CAUSE_LEVEL
         |-> fault_info_o.cause == cause_x;
   endproperty
   a_cause: assert property (p_cause) else $error("bad cause code");
   property p_hold;
      tbl_rd_o && !tbl_ack_i |=> tbl_rd_o && $stable(tbl_addr_o);
   endproperty
   a_hold: assert property (p_hold) else $error("read not held");
   property p_dma_wb;
      tbl_wr_o |-> !dma_q && tbl_wdata_o[0];
   endproperty
   a_dma_wb: assert property (p_dma_wb) else $error("bad write-back");
   property p_dirty;
      tbl_wr_o |-> tbl_wdata_o[31:3] == rd_q[31:3] && tbl_addr_o == rda_q &&
         (tbl_wdata_o[2] == rd_q[2] || acc_q == sat_pkg::ACC_WRITE);
   endproperty
   a_dirty: assert property (p_dirty) else $error("entry altered");
endmodule

bind sat_translator sat_translator_properties chk_u (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .xlat_enable_i(xlat_enable_i), .proc_desc_i(proc_desc_i),
   .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o),
   .fault_info_o(fault_info_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .tbl_rd_o(tbl_rd_o),
   .tbl_wr_o(tbl_wr_o), .tbl_addr_o(tbl_addr_o), .tbl_wdata_o(tbl_wdata_o), .tbl_rdata_i(tbl_rdata_i),
   .tbl_ack_i(tbl_ack_i)
);

// ===== tb/sat_mem_model.sv
// table memory answering entry reads and write-backs
`timescale 1ns/1ns
module sat_mem_model (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic tbl_rd_i,
   input wire logic tbl_wr_i,
   input wire logic [23:0] tbl_addr_i,
   input wire logic [31:0] tbl_wdata_i,
   input wire logic [1:0] lat_i,
   output logic [31:0] tbl_rdata_o,
   output logic tbl_ack_o
);
   logic [31:0] mem [0:4095];
   logic [1:0] wait_q;
   logic pend;
   assign pend = !tbl_ack_o && (tbl_rd_i || tbl_wr_i);
   // data toggles outside an answer so stale words never look valid
   always @(posedge core_clk_i) begin
      if (rst_i) begin
         tbl_ack_o <= 1'b0;
         wait_q <= 2'h0;
         tbl_rdata_o <= 32'h0;
      end else if (pend && wait_q < lat_i) begin
         wait_q <= wait_q + 2'h1;
         tbl_rdata_o <= ~tbl_rdata_o;
      end else begin
         tbl_ack_o <= pend;
         wait_q <= 2'h0;
         if (pend && tbl_wr_i) mem[tbl_addr_i[14:3]] <= tbl_wdata_i;
         tbl_rdata_o <= (pend && tbl_rd_i) ? mem[tbl_addr_i[14:3]] : ~tbl_rdata_o;
      end
   end
endmodule

// ===== tb/sat_translator_tb.sv
// self-checking bench for the segment address translator
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("Error at %0t: got %h exp %h", $time, g, e); end end
module sat_translator_tb;
   typedef struct packed {
      logic flt;
      sat_pkg::sat_fault_t info;
      sat_pkg::sat_acc_t acc;
      logic [23:0] addr;
   } sat_exp_t;
   // process table at 0x1000, highest index 8; shared table at 0x2000, highest index 16
   localparam logic [31:0] PDESC = 32'h00100020;
   localparam logic [31:0] SDESC = 32'h00200040;
   logic core_clk_i, rst_i, xlat_enable_i, req_valid_i, busy_o, done_o, fault_o, mem_req_o;
   logic tbl_rd_o, tbl_wr_o, tbl_ack_i;
   logic [31:0] proc_desc_i, shr_desc_i, tbl_wdata_o, tbl_rdata_i;
   logic [23:0] mem_addr_o, tbl_addr_o;
   logic [1:0] pstat_level_i, lat;
   sat_pkg::sat_req_t req_i;
   sat_pkg::sat_fault_t fault_info_o;
   sat_pkg::sat_acc_t mem_acc_o;
   sat_exp_t exp_q[$];
   sat_exp_t cur;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   logic [31:0] f_in [5] = '{32'h1460003a, 32'h1460003a, 32'h1460003a, 32'h14600038, 32'h146000c2};
   logic [31:0] f_out [5] = '{32'h1460003f, 32'h1460003a, 32'h1460003b, 32'h14600039, 32'h146000c3};
   logic [1:0] f_acc [5] = '{2'h1, 2'h1, 2'h2, 2'h1, 2'h1};
   logic [4:0] f_dma = 5'h02;

   sat_translator dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .xlat_enable_i(xlat_enable_i),
      .proc_desc_i(proc_desc_i), .shr_desc_i(shr_desc_i), .pstat_level_i(pstat_level_i),
      .req_valid_i(req_valid_i), .req_i(req_i), .busy_o(busy_o), .done_o(done_o), .fault_o(fault_o),
      .fault_info_o(fault_info_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o), .mem_acc_o(mem_acc_o),
      .tbl_rd_o(tbl_rd_o), .tbl_wr_o(tbl_wr_o), .tbl_addr_o(tbl_addr_o), .tbl_wdata_o(tbl_wdata_o),
      .tbl_rdata_i(tbl_rdata_i), .tbl_ack_i(tbl_ack_i));
   sat_mem_model mem_u (.core_clk_i(core_clk_i), .rst_i(rst_i), .tbl_rd_i(tbl_rd_o), .tbl_wr_i(tbl_wr_o),
      .tbl_addr_i(tbl_addr_o), .tbl_wdata_i(tbl_wdata_o), .lat_i(lat), .tbl_rdata_o(tbl_rdata_i),
      .tbl_ack_o(tbl_ack_i));

   always #50 core_clk_i = ~core_clk_i;

   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   always @(posedge core_clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         end_sim();
      end
   end

   function automatic sat_exp_t expect_of(input sat_pkg::sat_req_t r, input logic en, input logic [1:0] lvl);
      sat_exp_t e;
      logic [31:0] pe, fe;
      logic [2:0] md;
      logic [23:0] a;
      e = '0;
      e.acc = r.acc;
      a = 24'h001000 + {13'h0000, r.prog_addr[15:8], 3'h0};
      pe = mem_u.mem[a[14:3]];
      fe = pe;
      md = pe[5:3];
      if (pe[1] && pe[8]) begin
         a = 24'h002000 + {7'h00, pe[31:15]};
         fe = mem_u.mem[a[14:3]];
         md = md & fe[5:3];
      end
      e.addr = {fe[31:15], 7'h00} + {8'h00, r.prog_addr[15:0]};
      if (!en) e.addr = r.prog_addr[23:0];
      else if (r.prog_addr[15:8] > 8'h08) e.info.kind = sat_pkg::FLT_SEG_CNT;
      else if (pe[1] && pe[8] && pe[14:10] > 5'h10) e.info.kind = sat_pkg::FLT_SHR_SIZE;
      else if (pe[1] && pe[8] && pe[31:15] > 17'h00080) e.info.kind = sat_pkg::FLT_SHR_OFF;
      else if (!fe[1]) e.info.kind = sat_pkg::FLT_ABSENT;
      else if (lvl < fe[7:6] || !md[r.acc]) begin
         e.info.kind = sat_pkg::FLT_PROT;
         e.info.cause = (lvl < fe[7:6]) ? 2'h3 : 2'h2 - 2'(r.acc);
      end else if (fe[14:10] < r.prog_addr[12:8]) e.info.kind = sat_pkg::FLT_LIMIT;
      e.flt = e.info.kind != sat_pkg::FLT_NONE;
      return e;
   endfunction

   function automatic logic [31:0] rand_ent(input logic process_segment_table);
      logic [31:0] w;
      w = $urandom;
      w[9] = 1'b0;
      w[1] = ($urandom % 4) != 0;
      w[8] = process_segment_table && w[8];
      if (w[8]) w[31:15] = 17'(($urandom % 20) * 8);
      else w[19:15] = 5'h00;
      return w;
   endfunction

   // request held until taken; expectation noted at the taking edge
   task automatic issue(input sat_pkg::sat_req_t r, input logic en, input logic [1:0] lvl);
      logic b;
      @(posedge core_clk_i);
      req_valid_i <= 1'b1;
      req_i <= r;
      xlat_enable_i <= en;
      pstat_level_i <= lvl;
      lat <= 2'($urandom % 3);
      do begin
         @(negedge core_clk_i);
         b = busy_o;
         @(posedge core_clk_i);
      end while (b !== 1'b0);
      exp_q.push_back(expect_of(r, en, lvl));
   endtask

   task automatic idle();
      @(posedge core_clk_i);
      req_valid_i <= 1'b0;
      for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(posedge core_clk_i);
   endtask

   always @(negedge core_clk_i) begin
      if (!rst_i && done_o === 1'b1) begin
         if (exp_q.size() == 0) `CHK(done_o, 1'b0)
         else begin
            cur = exp_q.pop_front();
            `CHK(fault_o, cur.flt)
            `CHK(mem_req_o, !cur.flt)
            `CHK(fault_info_o.kind, cur.info.kind)
            if (cur.info.kind == sat_pkg::FLT_PROT) `CHK(fault_info_o.cause, cur.info.cause)
            if (!cur.flt) begin
               `CHK(mem_addr_o, cur.addr)
               `CHK(mem_acc_o, cur.acc)
            end
         end
      end
   end

   initial begin
      sat_pkg::sat_req_t r;
      core_clk_i = 1'b0;
      rst_i = 1'b1;
      xlat_enable_i = 1'b0;
      proc_desc_i = PDESC;
      shr_desc_i = SDESC;
      pstat_level_i = 2'h0;
      req_valid_i = 1'b0;
      req_i = '0;
      lat = 2'h0;
      void'($urandom(32'hb29a));
      for (int i = 0; i < 10; i++) mem_u.mem[12'h200 + i] = rand_ent(1'b1);
      for (int i = 0; i < 20; i++) mem_u.mem[12'h400 + i] = rand_ent(1'b0);
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 300; i++) begin
         r.prog_addr = $urandom;
         r.prog_addr[15:8] = 8'($urandom % 10);
         r.acc = sat_pkg::sat_acc_t'($urandom % 3);
         r.dma = ($urandom % 4) == 0;
         issue(r, ($urandom % 8) != 0, 2'($urandom % 4));
      end
      idle();
      $display("test random_walk done");
      for (int i = 0; i < 5; i++) begin
         mem_u.mem[12'h200] = f_in[i];
         r.prog_addr = 32'h12340056;
         r.acc = sat_pkg::sat_acc_t'(f_acc[i]);
         r.dma = f_dma[i];
         issue(r, 1'b1, 2'h0);
         idle();
         `CHK(mem_u.mem[12'h200], f_out[i])
      end
      $display("test entry_flags done");
      end_sim();
   end
endmodule
